// file: shared/sup_pkg.sv
`default_nettype none
package sup_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_OPER = 8'h01;
  localparam logic [7:0] ADDR_VIN_ON = 8'h35;
  localparam logic [7:0] ADDR_VIN_OFF = 8'h36;
  localparam logic [7:0] ADDR_OV = 8'h55;
  localparam logic [7:0] ADDR_PCFG = 8'hC4;
  localparam logic [7:0] ADDR_SSTO = 8'hC7;
  localparam logic [7:0] ADDR_GUARD = 8'hE6;
  localparam logic [7:0] ADDR_MODE = 8'hF4;
  localparam logic [7:0] ADDR_CAPT = 8'hFA;
  // Reset values
  localparam logic [15:0] RST_VIN_ON = 16'h0000;
  localparam logic [15:0] RST_VIN_OFF = 16'h0000;
  localparam logic [15:0] RST_OV = 16'hFFFF;
  localparam logic [15:0] RST_PCFG = 16'h0080;
  localparam logic [15:0] RST_SSTO = 16'h0258;
  localparam logic [15:0] RST_GUARD = 16'h0001;
  localparam logic [15:0] RST_MODE = 16'h0A07;
  // Field positions
  localparam int OPER_ON_BIT = 7;
  localparam int PCFG_UNDERVOLTAGE_LOCKOUT_MODE_BIT = 7;
  localparam int PCFG_SSTO_HICCUP_BIT = 13;
  localparam int GUARD_UNDERVOLTAGE_LOCKOUT_EN_BIT = 0;
  localparam int MODE_GOK_BIT = 0;
  localparam int MODE_OV_BIT = 1;
  localparam int MODE_NFO_BIT = 2;
  localparam int MODE_RETRY_LSB = 8;
  localparam int MODE_RETRY_W = 8;
  localparam int SSTO_W = 10;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int HOLD_NS = 50000;
  localparam int HOLD_CYC = HOLD_NS * CLK_MHZ / 1000;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / 1000 * CLK_MHZ;
  localparam logic [15:0] NFO_MS = 16'h00FA;
  localparam logic [15:0] SSTO_MAX_MS = 16'h0258;
  localparam logic [15:0] INSERT_MS = 16'h0010;
  // Pending fault vector
  localparam int P_GOK = 0;
  localparam int P_SHORT = 1;
  localparam int P_NFO = 2;
  localparam int P_OV = 3;
  localparam int P_SSTO = 4;
  localparam int P_PROV = 5;
  localparam int PEND_W = 6;
  // Fault-type levels, higher value wins
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_GOK = 3'h1;
  localparam logic [2:0] CODE_SHORT = 3'h2;
  localparam logic [2:0] CODE_OVT = 3'h3;
  localparam logic [2:0] CODE_OCP = 3'h4;
  localparam logic [2:0] CODE_SCP = 3'h5;
  // Code display selection
  typedef enum logic [1:0] {SHOW_NONE, SHOW_PEND, SHOW_GOK} show_t;
  // Synchronised pin inputs
  localparam int I_AUX = 0;
  localparam int I_VR = 1;
  localparam int I_VF = 2;
  localparam int I_EN = 3;
  localparam int I_ON = 4;
  localparam int I_GOK = 5;
  localparam int I_SS = 6;
  localparam int I_AOV = 7;
  localparam int I_OVF = 8;
  localparam int I_V90 = 9;
  localparam int I_NFO = 10;
  localparam int I_OC = 11;
  localparam int SYN_W = 12;
endpackage : sup_pkg
`default_nettype wire

// file: shared/sup_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sup_if;
  import sup_pkg::*;
  logic [PEND_W-1:0] pend;
  show_t show;
  logic [2:0] code;
  logic restart;
  logic tick;
  logic [15:0] elapsed;
  modport ctl (output pend, show, restart, tick, input code, elapsed);
  modport enc (input pend, show, output code);
  modport tmr (input restart, tick, output elapsed);
endinterface : sup_if
`default_nettype wire

// file: logic/fault_level_enc.sv
`timescale 1ns/1ps
`default_nettype none
module fault_level_enc import sup_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fault side
  sup_if.enc f
);
  typedef struct packed {
    logic [2:0] code_r;
  } enc_t;
  enc_t q, d;
  logic [2:0] top;

  always_comb begin
    top = CODE_NONE;
    if (f.pend[P_OV]) begin
      top = CODE_OVT;
    end else if (f.pend[P_SHORT] || f.pend[P_NFO]) begin
      top = CODE_SHORT;
    end else if (|f.pend) begin
      top = CODE_GOK;
    end
    d = q;
    unique case (f.show)
      SHOW_NONE: d.code_r = CODE_NONE;
      SHOW_PEND: d.code_r = top;
      SHOW_GOK: d.code_r = CODE_GOK;
      default: d.code_r = CODE_NONE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign f.code = q.code_r;
endmodule : fault_level_enc
`default_nettype wire

// file: logic/ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ms_timer import sup_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control side
  sup_if.tmr t
);
  typedef struct packed {
    logic [15:0] cnt_r;
  } tmr_t;
  tmr_t q, d;

  always_comb begin
    d = q;
    if (t.restart) begin
      d.cnt_r = '0;
    end else if (t.tick && q.cnt_r != 16'hFFFF) begin
      d.cnt_r = q.cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.elapsed = q.cnt_r;
endmodule : ms_timer
`default_nettype wire

// file: logic/hot_swap_fault_supervisor.sv
// Function
// - Programmable overvoltage pulls ON, fault, soft-start low
// - Absolute overvoltage turns off, shows overvoltage code
// - Latched overvoltage recovers only below falling level
// - Hiccup overvoltage retries after delay below level
// - Output above 90% during insertion flags short
// - Short shows code, stays off until cycle/command
// - Not-fully-on switch turns off after 250 ms
// - Not-fully-on shows short code then slave code
// - Latch-off waits for power cycle or command
// - Hiccup waits retry delay then restarts
// - Soft-start timer expiry below enhancement is fault
// - Timeout mode and duration programmable, 600 ms cap
// - Low shared line: slave code, delayed off
// - Shared-line fault mode set by response register
// - Fixed plus programmable input undervoltage lockout
// - Programmable lockout enable and mode bits
// - Start needs aux and input above rising levels
// - Shut down on aux or input falling levels
// - Undervoltage never latches, resumes automatically
// - Master of shared ON, soft-start, fault lines
// - Higher code level wins among pending faults
// - Fault line drops now, ON after hold (at once for programmable overvoltage or soft-start timeout), capture
`timescale 1ns/1ps
`default_nettype none
module hot_swap_fault_supervisor import sup_pkg::*; #(
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Input voltage sample
  input wire logic [15:0] vin_sample,
  // Comparator pins
  input wire logic aux_supply_ok,
  input wire logic vin_above_abs_rise,
  input wire logic vin_above_abs_fall,
  input wire logic enable_in,
  input wire logic vin_above_abs_ov,
  input wire logic vin_above_ov_fall,
  input wire logic vout_above_90pct,
  input wire logic ss_near_aux_low_gate,
  input wire logic oc_or_sc_event,
  input wire logic ss_above_enh,
  // ON pin
  input wire logic on_pin_in,
  output logic on_pin_out,
  output logic on_pin_oe_n,
  // Soft-start pin
  output logic ss_pin_out,
  output logic ss_pin_oe_n,
  // Shared fault line
  input wire logic shared_fault_line_in,
  output logic shared_fault_line_out,
  output logic shared_fault_line_oe_n,
  // Switch and fault type
  output logic switch_enable,
  output logic [2:0] fault_code_output
);
  typedef enum logic [2:0] {S_DOWN, S_START, S_RUN, S_HOLD, S_LATCH, S_WAIT, S_RETRY} st_t;

  typedef struct packed {
    logic [SYN_W-1:0] s1_r;
    logic [SYN_W-1:0] s2_r;
    st_t st_r;
    logic [PEND_W-1:0] pend_r;
    logic [15:0] vin_on_r;
    logic [15:0] vin_off_r;
    logic [15:0] ov_r;
    logic [15:0] pcfg_r;
    logic [15:0] ssto_r;
    logic [15:0] guard_r;
    logic [15:0] mode_r;
    logic [2:0] capt_r;
    logic [15:0] rdata_r;
    logic [31:0] pre_r;
    logic [31:0] hold_r;
    logic sw_r;
  } sup_t;

  sup_t q, d;
  sup_if f ();
  logic [SYN_W-1:0] pins;
  logic [PEND_W-1:0] hic;
  logic on_cmd, pwr_ok, pwr_fail, latched, clr_ok, tick;
  logic fault_now, drive_on, drive_ss, drive_fl;
  logic [PEND_W-1:0] det;
  logic [15:0] ss_lim;
  show_t show;

  fault_level_enc u_enc (
    .clock(clock),
    .rst(rst),
    .f(f.enc)
  );

  ms_timer u_tmr (
    .clock(clock),
    .rst(rst),
    .t(f.tmr)
  );

  assign pins = {oc_or_sc_event, ss_near_aux_low_gate, vout_above_90pct,
                 vin_above_ov_fall, vin_above_abs_ov, ss_above_enh,
                 shared_fault_line_in, on_pin_in, enable_in,
                 vin_above_abs_fall, vin_above_abs_rise, aux_supply_ok};

  always_comb begin
    d = q;
    d.s1_r = pins;
    d.s2_r = q.s1_r;
    tick = (q.pre_r == 32'(MS_CYCLES - 1));
    d.pre_r = tick ? 32'h00000000 : q.pre_r + 32'h00000001;
    on_cmd = reg_wr && reg_addr == ADDR_OPER && reg_wdata[OPER_ON_BIT];
    // Effective levels: both fixed and programmable must pass
    pwr_ok = q.s2_r[I_AUX] && q.s2_r[I_VR] && q.s2_r[I_EN]
             && (!q.guard_r[GUARD_UNDERVOLTAGE_LOCKOUT_EN_BIT] || vin_sample >= q.vin_on_r);
    pwr_fail = !q.s2_r[I_AUX] || !q.s2_r[I_VF] || !q.s2_r[I_EN]
               || (q.guard_r[GUARD_UNDERVOLTAGE_LOCKOUT_EN_BIT] && q.pcfg_r[PCFG_UNDERVOLTAGE_LOCKOUT_MODE_BIT]
                   && vin_sample < q.vin_off_r);
    // Per-fault restart mode
    hic = '0;
    hic[P_GOK] = q.mode_r[MODE_GOK_BIT];
    hic[P_OV] = q.mode_r[MODE_OV_BIT];
    hic[P_PROV] = q.mode_r[MODE_OV_BIT];
    hic[P_NFO] = q.mode_r[MODE_NFO_BIT];
    hic[P_SSTO] = q.pcfg_r[PCFG_SSTO_HICCUP_BIT];
    latched = |(q.pend_r & ~hic);
    clr_ok = !(q.pend_r[P_OV] && q.s2_r[I_OVF])
             && !(q.pend_r[P_PROV] && vin_sample > q.ov_r);
    ss_lim = {6'h00, q.ssto_r[SSTO_W-1:0]};
    if (ss_lim > SSTO_MAX_MS) begin
      ss_lim = SSTO_MAX_MS;
    end
    // Fault detection while the switch is active
    det = '0;
    if (q.st_r == S_START || q.st_r == S_RUN) begin
      det[P_PROV] = vin_sample > q.ov_r;
      det[P_OV] = q.s2_r[I_AOV];
      det[P_GOK] = !q.s2_r[I_GOK];
    end
    if (q.st_r == S_START) begin
      det[P_SHORT] = q.s2_r[I_V90] && f.elapsed < INSERT_MS;
      det[P_SSTO] = f.elapsed >= ss_lim && !q.s2_r[I_SS];
    end
    if (q.st_r == S_RUN) begin
      det[P_NFO] = f.elapsed >= NFO_MS;
    end
    fault_now = |det;
    f.restart = 1'b0;
    show = SHOW_NONE;
    d.hold_r = '0;
    unique case (q.st_r)
      S_DOWN: begin
        d.sw_r = 1'b0;
        d.pend_r = '0;
        // A falling-level failure must also be clear, or the switch would toggle
        if (pwr_ok && !pwr_fail && q.s2_r[I_ON]) begin
          d.st_r = S_START;
          f.restart = 1'b1;
          d.sw_r = 1'b1;
        end
      end
      S_START: begin
        if (fault_now) begin
          d.pend_r = q.pend_r | det;
          d.st_r = S_HOLD;
          d.sw_r = det[P_GOK] && !(|(det & ~(PEND_W'(1) << P_GOK)));
        end else if (q.s2_r[I_SS] && f.elapsed >= INSERT_MS) begin
          d.st_r = S_RUN;
          f.restart = 1'b1;
        end
      end
      S_RUN: begin
        f.restart = !(q.s2_r[I_NFO] && !q.s2_r[I_OC]);
        if (fault_now) begin
          d.pend_r = q.pend_r | det;
          d.st_r = S_HOLD;
          d.sw_r = det[P_GOK] && !(|(det & ~(PEND_W'(1) << P_GOK)));
        end
      end
      S_HOLD: begin
        show = SHOW_PEND;
        d.hold_r = q.hold_r + 32'h00000001;
        if (q.hold_r == 32'(HOLD_CYCLES - 1)) begin
          d.sw_r = 1'b0;
          d.capt_r = f.code;
          d.st_r = latched ? S_LATCH : S_WAIT;
        end
      end
      S_LATCH: begin
        show = SHOW_GOK;
        if (on_cmd && clr_ok) begin
          d.st_r = S_DOWN;
        end
      end
      S_WAIT: begin
        show = SHOW_GOK;
        f.restart = 1'b1;
        if (clr_ok) begin
          d.st_r = S_RETRY;
        end
      end
      S_RETRY: begin
        show = SHOW_GOK;
        if (f.elapsed >= 16'(q.mode_r[MODE_RETRY_LSB +: MODE_RETRY_W])) begin
          d.st_r = S_DOWN;
        end
      end
      default: d.st_r = S_DOWN;
    endcase
    if (pwr_fail && q.st_r != S_DOWN) begin
      d.st_r = S_DOWN;
      d.sw_r = 1'b0;
    end
    f.show = show;
    f.tick = tick;
    f.pend = q.pend_r;
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_VIN_ON: d.vin_on_r = reg_wdata;
        ADDR_VIN_OFF: d.vin_off_r = reg_wdata;
        ADDR_OV: d.ov_r = reg_wdata;
        ADDR_PCFG: d.pcfg_r = reg_wdata;
        ADDR_SSTO: d.ssto_r = reg_wdata;
        ADDR_GUARD: d.guard_r = reg_wdata;
        ADDR_MODE: d.mode_r = reg_wdata;
        default: ;
      endcase
    end
    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_VIN_ON: d.rdata_r = q.vin_on_r;
        ADDR_VIN_OFF: d.rdata_r = q.vin_off_r;
        ADDR_OV: d.rdata_r = q.ov_r;
        ADDR_PCFG: d.rdata_r = q.pcfg_r;
        ADDR_SSTO: d.rdata_r = q.ssto_r;
        ADDR_GUARD: d.rdata_r = q.guard_r;
        ADDR_MODE: d.rdata_r = q.mode_r;
        ADDR_CAPT: d.rdata_r = {13'h0000, q.capt_r};
        default: d.rdata_r = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st_r <= S_DOWN;
      q.vin_on_r <= RST_VIN_ON;
      q.vin_off_r <= RST_VIN_OFF;
      q.ov_r <= RST_OV;
      q.pcfg_r <= RST_PCFG;
      q.ssto_r <= RST_SSTO;
      q.guard_r <= RST_GUARD;
      q.mode_r <= RST_MODE;
    end else begin
      q <= d;
    end
  end

  // Pin drive: ON low off-line and at once for immediate faults
  always_comb begin
    drive_fl = q.st_r == S_HOLD || q.st_r == S_LATCH || q.st_r == S_WAIT
               || q.st_r == S_RETRY;
    drive_ss = !(q.st_r == S_START || q.st_r == S_RUN);
    drive_on = q.st_r == S_LATCH || q.st_r == S_WAIT || q.st_r == S_RETRY
               || (q.st_r == S_DOWN && (!pwr_ok || pwr_fail))
               || (q.st_r == S_HOLD && (q.pend_r[P_PROV] || q.pend_r[P_SSTO]));
  end

  assign on_pin_out = 1'b0;
  assign on_pin_oe_n = !drive_on;
  assign ss_pin_out = 1'b0;
  assign ss_pin_oe_n = !drive_ss;
  assign shared_fault_line_out = 1'b0;
  assign shared_fault_line_oe_n = !drive_fl;
  assign switch_enable = q.sw_r;
  assign fault_code_output = f.code;
  assign reg_rdata = q.rdata_r;
endmodule : hot_swap_fault_supervisor
`default_nettype wire

// file: verif/hot_swap_fault_supervisor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sup_checker import sup_pkg::*; #(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched pins
  input wire logic aux_supply_ok,
  input wire logic vin_above_abs_rise,
  input wire logic vin_above_abs_fall,
  input wire logic enable_in,
  input wire logic vin_above_abs_ov,
  input wire logic on_pin_in,
  input wire logic shared_fault_line_in,
  input wire logic shared_fault_line_oe_n,
  input wire logic switch_enable,
  input wire logic [2:0] fault_code_output
);
  logic [15:0] run_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Cycles the code has stayed above the slave level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) run_r <= 16'h0000;
    else if (fault_code_output > CODE_GOK) run_r <= run_r + 16'h0001;
    else run_r <= 16'h0000;
  end
  a_ov_turns_off: assert property (
    (vin_above_abs_ov && shared_fault_line_oe_n && switch_enable)[*3]
      |=> !switch_enable && !shared_fault_line_oe_n
  ) else $error("overvoltage did not shut down");
  a_fault_shows_code: assert property (
    $fell(shared_fault_line_oe_n) |-> ##[1:3] fault_code_output != CODE_NONE
  ) else $error("fault line pulled without code");
  a_code_holds: assert property (
    $rose(fault_code_output > CODE_GOK) |-> (fault_code_output > CODE_GOK)[*8]
  ) else $error("fault code dropped early");
  a_hold_length: assert property (
    $fell(fault_code_output > CODE_GOK) |-> fault_code_output == CODE_GOK
      && run_r >= 16'(HOLD_CYCLES - 2) && run_r <= 16'(HOLD_CYCLES + 2)
  ) else $error("hold interval wrong");
  a_start_qualified: assert property (
    $rose(switch_enable) |-> $past(aux_supply_ok, 3) && $past(vin_above_abs_rise, 3)
      && $past(enable_in, 3) && $past(on_pin_in, 3)
  ) else $error("switch on without supplies");
  a_power_fail_off: assert property (
    (!aux_supply_ok || !vin_above_abs_fall || !enable_in)[*3] |=> !switch_enable
  ) else $error("switch on after supply loss");
  a_slave_fault_code: assert property (
    (switch_enable && shared_fault_line_oe_n && !shared_fault_line_in)[*3]
      |=> ##[0:2] fault_code_output != CODE_NONE
  ) else $error("slave fault not shown");
  a_no_restart: assert property (
    fault_code_output == CODE_GOK && !switch_enable |=> !switch_enable
  ) else $error("switch on while fault shown");
endmodule : sup_checker
bind hot_swap_fault_supervisor sup_checker #(.HOLD_CYCLES(HOLD_CYCLES)) sup_checker_i (
  .clock, .rst, .aux_supply_ok, .vin_above_abs_rise, .vin_above_abs_fall, .enable_in,
  .vin_above_abs_ov, .on_pin_in, .shared_fault_line_in, .shared_fault_line_oe_n,
  .switch_enable, .fault_code_output);
`default_nettype wire

// file: verif/phase_model.sv
`timescale 1ns/1ps
`default_nettype none
module phase_model (
  // Clock
  input wire logic clock,
  // Device drives
  input wire logic on_oe_n,
  input wire logic ss_oe_n,
  input wire logic flt_oe_n,
  // Bench controls
  input wire logic on_req,
  input wire logic phase_fault,
  input wire logic [15:0] ramp,
  // Resolved lines
  output logic on_line,
  output logic flt_line,
  output logic ss_enh
);
  logic [15:0] ss_cnt;
  assign on_line = on_req && on_oe_n;
  assign flt_line = flt_oe_n && !phase_fault;
  always_ff @(posedge clock) begin
    if (!ss_oe_n || !on_line) ss_cnt <= 16'h0000;
    else if (ss_cnt != 16'hFFFF) ss_cnt <= ss_cnt + 16'h0001;
  end
  assign ss_enh = ss_cnt >= ramp;
endmodule : phase_model
`default_nettype wire

// file: verif/hot_swap_fault_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module hot_swap_fault_supervisor_tb;
  import sup_pkg::*;
  localparam int HOLD = 20;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, vin_sample = 16'h0100, d;
  logic aux_supply_ok = 0, vin_above_abs_rise = 0, vin_above_abs_fall = 0, enable_in = 0;
  logic vin_above_abs_ov = 0, vin_above_ov_fall = 0, vout_above_90pct = 0;
  logic ss_near_aux_low_gate = 0, oc_or_sc_event = 0, on_req = 0, phase_fault = 0;
  logic ss_above_enh, on_pin_in, shared_fault_line_in, on_pin_out, on_pin_oe_n;
  logic ss_pin_out, ss_pin_oe_n, shared_fault_line_out, shared_fault_line_oe_n, switch_enable;
  logic [2:0] fault_code_output;
  logic [15:0] ramp = 16'h0005;
  logic [31:0] seed = 32'hB432;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] ra [7] = '{ADDR_VIN_ON, ADDR_VIN_OFF, ADDR_OV, ADDR_PCFG, ADDR_SSTO, ADDR_GUARD,
    ADDR_MODE};
  logic [15:0] rv [7] = '{RST_VIN_ON, RST_VIN_OFF, RST_OV, RST_PCFG, RST_SSTO, RST_GUARD,
    RST_MODE};
  hot_swap_fault_supervisor #(.HOLD_CYCLES(HOLD), .MS_CYCLES(10)) hot_swap_fault_supervisor_i (
    .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .vin_sample,
    .aux_supply_ok, .vin_above_abs_rise, .vin_above_abs_fall, .enable_in, .vin_above_abs_ov,
    .vin_above_ov_fall, .vout_above_90pct, .ss_near_aux_low_gate, .oc_or_sc_event,
    .ss_above_enh, .on_pin_in, .on_pin_out, .on_pin_oe_n, .ss_pin_out, .ss_pin_oe_n,
    .shared_fault_line_in, .shared_fault_line_out, .shared_fault_line_oe_n, .switch_enable,
    .fault_code_output);
  phase_model phase_model_i (.clock, .on_oe_n(on_pin_oe_n), .ss_oe_n(ss_pin_oe_n),
    .flt_oe_n(shared_fault_line_oe_n), .on_req, .phase_fault, .ramp, .on_line(on_pin_in),
    .flt_line(shared_fault_line_in), .ss_enh(ss_above_enh));
  initial forever #5 clock = ~clock;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic hiccup(logic [15:0] w, int b);
    return w[b];
  endfunction : hiccup
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(negedge clock);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clock);
    reg_wr = 0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [15:0] v);
    @(negedge clock);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 0;
    @(negedge clock);
    v = reg_rdata;
  endtask : rd
  task automatic await_sw(logic v, int lim);
    int i;
    for (i = 0; i < lim && switch_enable !== v; i++) @(negedge clock);
    `CHK("switch", v, switch_enable)
    if (i == lim) results();
  endtask : await_sw
  task automatic see_fault(logic [2:0] c);
    int i;
    for (i = 0; i < 4000 && fault_code_output !== c; i++) @(negedge clock);
    `CHK("code", c, fault_code_output)
    if (i == 4000) results();
    cyc(HOLD + 4);
    `CHK("code after hold", CODE_GOK, fault_code_output)
    `CHK("fault line", 1'b0, shared_fault_line_oe_n)
    rd(ADDR_CAPT, d);
    `CHK("captured", {13'h0000, c}, d)
  endtask : see_fault
  task automatic recover(logic h);
    if (!h) begin
      cyc(300);
      `CHK("latched", 1'b0, switch_enable)
      wr(ADDR_OPER, 16'h0080);
    end
    await_sw(1'b1, 300);
    cyc(200);
  endtask : recover
  initial begin
    int m;
    logic [15:0] mw;
    repeat (8) @(negedge clock);
    rst = 0;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      `CHK("reset value", rv[i], d)
      if (ra[i] != ADDR_SSTO) begin
        seed = lfsr(seed);
        wr(ra[i], seed[15:0]);
        rd(ra[i], d);
        `CHK("read back", seed[15:0], d)
        wr(ra[i], rv[i]);
      end
    end
    rd(8'h20, d);
    `CHK("unmapped", 16'h0000, d)
    wr(ADDR_CAPT, 16'hFFFF);
    rd(ADDR_CAPT, d);
    `CHK("capture", 16'h0000, d)
    seed = lfsr(seed);
    vin_sample = {8'h01, seed[7:0]};
    ramp = {11'h000, seed[12:8]} + 16'h0001;
    wr(ADDR_VIN_ON, vin_sample + 16'h0001);
    aux_supply_ok = 1;
    vin_above_abs_rise = 1;
    vin_above_abs_fall = 1;
    enable_in = 1;
    on_req = 1;
    cyc(50);
    `CHK("lockout", 1'b0, switch_enable)
    wr(ADDR_GUARD, 16'h0000);
    await_sw(1'b1, 50);
    wr(ADDR_VIN_ON, RST_VIN_ON);
    wr(ADDR_GUARD, RST_GUARD);
    wr(ADDR_VIN_OFF, vin_sample + 16'h0001);
    await_sw(1'b0, 50);
    wr(ADDR_VIN_OFF, RST_VIN_OFF);
    await_sw(1'b1, 50);
    aux_supply_ok = 0;
    await_sw(1'b0, 50);
    aux_supply_ok = 1;
    await_sw(1'b1, 50);
    cyc(200);
    `CHK("drive levels", 3'h0, {on_pin_out, ss_pin_out, shared_fault_line_out})
    for (m = 0; m < 2; m++) begin
      mw = {8'h0A, 5'h00, 2'b11, m[0]};
      wr(ADDR_MODE, mw);
      seed = lfsr(seed);
      phase_fault = 1;
      cyc(3 + seed[2:0]);
      phase_fault = 0;
      `CHK("slave hold", 1'b1, switch_enable)
      see_fault(CODE_GOK);
      recover(hiccup(mw, MODE_GOK_BIT));
    end
    for (m = 0; m < 2; m++) begin
      mw = {8'h0A, 5'h00, 1'b1, m[0], 1'b1};
      wr(ADDR_MODE, mw);
      vin_above_abs_ov = 1;
      vin_above_ov_fall = 1;
      see_fault(CODE_OVT);
      vin_above_abs_ov = 0;
      cyc(150);
      `CHK("above falling level", 1'b0, switch_enable)
      vin_above_ov_fall = 0;
      recover(hiccup(mw, MODE_OV_BIT));
    end
    vout_above_90pct = 1;
    aux_supply_ok = 0;
    cyc(10);
    aux_supply_ok = 1;
    see_fault(CODE_SHORT);
    vout_above_90pct = 0;
    recover(1'b0);
    oc_or_sc_event = 1;
    ss_near_aux_low_gate = 1;
    cyc(3000);
    `CHK("no trip on overcurrent", 1'b1, switch_enable)
    oc_or_sc_event = 0;
    see_fault(CODE_SHORT);
    ss_near_aux_low_gate = 0;
    recover(hiccup(RST_MODE, MODE_NFO_BIT));
    wr(ADDR_SSTO, 16'h0005);
    ramp = 16'hFFFF;
    aux_supply_ok = 0;
    cyc(10);
    aux_supply_ok = 1;
    see_fault(CODE_GOK);
    cyc(300);
    `CHK("timeout latched", 1'b0, switch_enable)
    wr(ADDR_PCFG, 16'h2080);
    wr(ADDR_OPER, 16'h0080);
    await_sw(1'b1, 50);
    cyc(40);
    `CHK("timer early", CODE_NONE, fault_code_output)
    see_fault(CODE_GOK);
    ramp = 16'h0005;
    await_sw(1'b1, 300);
    wr(ADDR_SSTO, RST_SSTO);
    cyc(200);
    wr(ADDR_OV, vin_sample - 16'h0001);
    cyc(5);
    `CHK("ON pulled", 1'b0, on_pin_oe_n)
    `CHK("SS pulled", 1'b0, ss_pin_oe_n)
    see_fault(CODE_GOK);
    wr(ADDR_OV, RST_OV);
    recover(1'b1);
    results();
  end
endmodule : hot_swap_fault_supervisor_tb
`default_nettype wire
